// ---- common/ift_pkg.sv ----
/*
 shared constants and carrier types of the fifo threshold and event
 clear block: register byte addresses, flag positions, widths and the
 packed state record.
 assumes a 32-bit axi4-lite register bus and one controller clock.
*/
package ift_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [31:0] ADDR_RAW_EVENT_STATUS = 32'h5000_1534;
   localparam logic [31:0] ADDR_RECEIVE_LEVEL = 32'h5000_1538;
   localparam logic [31:0] ADDR_TRANSMIT_LEVEL = 32'h5000_153c;
   localparam logic [31:0] ADDR_CLEAR_ALL = 32'h5000_1540;
   localparam logic [31:0] ADDR_CLEAR_RX_UNDER = 32'h5000_1544;
   localparam logic [31:0] ADDR_CLEAR_RX_OVER = 32'h5000_1548;
   localparam logic [31:0] ADDR_CLEAR_TX_OVER = 32'h5000_154c;
   localparam logic [31:0] ADDR_CLEAR_RD_REQ = 32'h5000_1550;
   localparam logic [31:0] ADDR_CLEAR_TX_ABORT = 32'h5000_1554;
   localparam logic [31:0] ADDR_CLEAR_SEND_DONE = 32'h5000_1558;
   localparam logic [31:0] ADDR_CLEAR_BUSY_SEEN = 32'h5000_155c;
   localparam logic [31:0] ADDR_ABORT_CAUSE = 32'h5000_1580;

   // ------------------------------------------------------------
   // field positions and widths
   // ------------------------------------------------------------
   localparam int TRIG_W = 5;
   localparam int FLAG_W = 9;
   localparam int CAUSE_W = 16;
   localparam int REG_W = 16;
   localparam int BIT_RX_UNDER = 0;
   localparam int BIT_RX_OVER = 1;
   localparam int BIT_RX_FULL = 2;
   localparam int BIT_TX_OVER = 3;
   localparam int BIT_TX_EMPTY = 4;
   localparam int BIT_RD_REQ = 5;
   localparam int BIT_TX_ABORT = 6;
   localparam int BIT_SEND_DONE = 7;
   localparam int BIT_BUSY_SEEN = 8;
   localparam int BIT_CAUSE_KEEP = 9;

   // ------------------------------------------------------------
   // reset values, tx top setting and bus answers
   // ------------------------------------------------------------
   localparam logic [TRIG_W-1:0] RX_TRIG_RESET = 5'h00;
   localparam logic [TRIG_W-1:0] TX_TRIG_RESET = 5'h00;
   localparam logic [TRIG_W-1:0] TX_TRIG_TOP = 5'h03;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // one-cycle event pulses from the controller core
   typedef struct packed {
      logic rx_under;
      logic rx_over;
      logic tx_over;
      logic rd_req;
      logic tx_abort;
      logic send_done;
      logic busy_seen;
   } ift_evt_type;

   // whole state of the block
   typedef struct packed {
      logic [TRIG_W-1:0] receive_level_trigger;
      logic [TRIG_W-1:0] transmit_level_trigger;
      logic [FLAG_W-1:0] raw_flags;
      logic [CAUSE_W-1:0] abort_cause_record;
      logic tx_flush;
      logic aw_got;
      logic w_got;
      logic [31:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } ift_state_type;

   localparam ift_state_type STATE_RESET = '{
      receive_level_trigger: RX_TRIG_RESET,
      transmit_level_trigger: TX_TRIG_RESET,
      default: '0};
endpackage

// ---- hdl/ift_event_clear.sv ----
/*
 fifo threshold registers and read-to-clear event flags of an i2c
 controller, reached over axi4-lite.
 assumes the controller core runs on aclk, gives its fifo levels,
 enable and activity as levels, and its events as one-cycle pulses.
*/
// Decided for this implementation: the AXI4-Lite register port.
// Contract
// - rx trigger in bits 4:0, level at or above
// - rx trigger setting plus one entries
// - tx trigger in bits 4:0, level at or below
// - tx setting 0 is zero, 3 is four
// - clear-all read clears soft flags and cause
// - clear-all leaves hardware level flags alone
// - underflow clear read clears bit 0
// - overflow clear read clears bit 1
// - tx overflow clear read clears bit 3
// - read request clear read clears bit 5
// - abort clear read clears bit 6, cause
// - abort clear read releases flushed tx fifo
// - send done clear read clears bit 7
// - busy clear read clears bit 8 when idle
// - busy flag kept while still active
// - busy flag self clears when disabled idle
// - rx level flag drops below trigger, disabled
// - abort flushes tx fifo until cleared
// - read request holds clock low till cleared
module ift_event_clear
   import ift_pkg::*;
#(
   parameter int LEVEL_W = 6
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // axi4-lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // controller core levels
   input wire logic core_enabled,
   input wire logic core_active,
   input wire logic [LEVEL_W-1:0] rx_fifo_level,
   input wire logic [LEVEL_W-1:0] tx_fifo_level,
   // controller core events
   input wire ift_evt_type core_events,
   input wire logic [CAUSE_W-1:0] abort_cause_set,
   input wire logic abort_cause_keep,
   // towards the controller core
   output logic tx_fifo_flush,
   output logic scl_hold_low,
   output logic intr_combined,
   output logic [FLAG_W-1:0] raw_event_status
);

   // ------------------------------------------------------------
   // state record
   // ------------------------------------------------------------
   ift_state_type s;
   ift_state_type next_s;

   // ------------------------------------------------------------
   // level flags and helpers
   // ------------------------------------------------------------
   logic [LEVEL_W-1:0] rx_trig_level;
   logic [LEVEL_W-1:0] tx_trig_level;
   logic [LEVEL_W-1:0] tx_seen_level;
   logic rx_full;
   logic tx_empty;
   logic idle_off;
   logic [FLAG_W-1:0] set_vec;
   logic [FLAG_W-1:0] full_flags;

   // rx trigger is the setting plus one entry
   assign rx_trig_level = LEVEL_W'(s.receive_level_trigger) +
                          LEVEL_W'(1);

   // tx setting 3 stands for four entries, lower settings as written
   // settings above 3 are compared as written, with no meaning
   always_comb begin
      if (s.transmit_level_trigger == TX_TRIG_TOP) begin
         tx_trig_level = LEVEL_W'(TX_TRIG_TOP) + LEVEL_W'(1);
      end else begin
         tx_trig_level = LEVEL_W'(s.transmit_level_trigger);
      end
   end

   // a flushed or disabled tx fifo looks empty
   assign tx_seen_level = (s.tx_flush || !core_enabled) ?
                          '0 : tx_fifo_level;

   // rx level flag drops by itself and when the controller is disabled
   assign rx_full = core_enabled &&
                    (rx_fifo_level >= rx_trig_level);

   // tx low water only counts while the state machines run
   assign tx_empty = (core_enabled || core_active) &&
                     (tx_seen_level <= tx_trig_level);

   // disabled and quiet: hardware may drop the under, over and busy sticky flags
   assign idle_off = !core_enabled && !core_active;

   // event pulses placed at their flag positions
   always_comb begin
      set_vec = '0;
      // pulses last one cycle, nothing is held here
      set_vec[BIT_RX_UNDER] = core_events.rx_under;
      set_vec[BIT_RX_OVER] = core_events.rx_over;
      set_vec[BIT_TX_OVER] = core_events.tx_over;
      set_vec[BIT_RD_REQ] = core_events.rd_req;
      set_vec[BIT_TX_ABORT] = core_events.tx_abort;
      set_vec[BIT_SEND_DONE] = core_events.send_done;
      set_vec[BIT_BUSY_SEEN] = core_events.busy_seen;
   end

   // sticky flags merged with the live level flags
   always_comb begin
      full_flags = s.raw_flags;
      full_flags[BIT_RX_FULL] = rx_full;
      full_flags[BIT_TX_EMPTY] = tx_empty;
   end

   // ------------------------------------------------------------
   // bus handshakes
   // ------------------------------------------------------------
   // readies drop with clk_en so no beat is taken while frozen
   assign s_axi_awready = clk_en && !s.bvalid && !s.aw_got;
   assign s_axi_wready = clk_en && !s.bvalid && !s.w_got;
   assign s_axi_arready = clk_en && !s.rvalid;

   // answers come straight from the state record
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rdata = s.rdata;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic do_write;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [FLAG_W-1:0] clr_vec;
   logic [FLAG_W-1:0] hw_clr;
   logic [CAUSE_W-1:0] cause_clr;
   logic flush_release;
   logic [REG_W-1:0] rd_word;
   logic [1:0] rd_resp;

   // a beat moves where valid meets ready
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;

   // either half may come first; the write waits for both
   assign do_write = (s.aw_got || aw_take) && (s.w_got || w_take);

   // a half taken earlier comes from the record, else from the pins
   assign wr_addr = s.aw_got ? s.awaddr : s_axi_awaddr;
   assign wr_data = s.w_got ? s.wdata : s_axi_wdata;
   assign wr_strb = s.w_got ? s.wstrb : s_axi_wstrb;

   // ------------------------------------------------------------
   // read decode
   // ------------------------------------------------------------
   // read decode: answer word and the clears the read causes
   always_comb begin
      rd_word = '0;
      rd_resp = RESP_OKAY;
      clr_vec = '0;
      cause_clr = '0;
      flush_release = 1'b0;
      case (s_axi_araddr)
         ADDR_RAW_EVENT_STATUS: begin
            rd_word = REG_W'(full_flags);
         end
         ADDR_RECEIVE_LEVEL: begin
            rd_word = REG_W'(s.receive_level_trigger);
         end
         ADDR_TRANSMIT_LEVEL: begin
            rd_word = REG_W'(s.transmit_level_trigger);
         end
         ADDR_ABORT_CAUSE: begin
            rd_word = s.abort_cause_record;
         end
         ADDR_CLEAR_ALL: begin
            // level flags bits 2 and 4 are never in clr_vec
            rd_word[0] = |full_flags;
            clr_vec = '1;
            clr_vec[BIT_RX_FULL] = 1'b0;
            clr_vec[BIT_TX_EMPTY] = 1'b0;
            clr_vec[BIT_BUSY_SEEN] = !core_active;
            cause_clr = '1;
            flush_release = 1'b1;
         end
         ADDR_CLEAR_RX_UNDER: begin
            rd_word[0] = s.raw_flags[BIT_RX_UNDER];
            clr_vec[BIT_RX_UNDER] = 1'b1;
         end
         ADDR_CLEAR_RX_OVER: begin
            rd_word[0] = s.raw_flags[BIT_RX_OVER];
            clr_vec[BIT_RX_OVER] = 1'b1;
         end
         ADDR_CLEAR_TX_OVER: begin
            rd_word[0] = s.raw_flags[BIT_TX_OVER];
            clr_vec[BIT_TX_OVER] = 1'b1;
         end
         ADDR_CLEAR_RD_REQ: begin
            rd_word[0] = s.raw_flags[BIT_RD_REQ];
            clr_vec[BIT_RD_REQ] = 1'b1;
         end
         ADDR_CLEAR_TX_ABORT: begin
            rd_word[0] = s.raw_flags[BIT_TX_ABORT];
            clr_vec[BIT_TX_ABORT] = 1'b1;
            cause_clr = '1;
            // the same read reopens the flushed tx fifo
            flush_release = 1'b1;
         end
         ADDR_CLEAR_SEND_DONE: begin
            rd_word[0] = s.raw_flags[BIT_SEND_DONE];
            clr_vec[BIT_SEND_DONE] = 1'b1;
         end
         ADDR_CLEAR_BUSY_SEEN: begin
            rd_word[0] = s.raw_flags[BIT_BUSY_SEEN];
            // while active the read reports but keeps the flag
            clr_vec[BIT_BUSY_SEEN] = !core_active;
         end
         default: begin
            rd_resp = RESP_SLVERR;
         end
      endcase
      // the kept cause bit survives both clearing reads
      if (abort_cause_keep) begin
         cause_clr[BIT_CAUSE_KEEP] = 1'b0;
      end
      // a read only clears when it is really taken
      if (!ar_take) begin
         clr_vec = '0;
         cause_clr = '0;
         flush_release = 1'b0;
      end
   end

   // hardware clears of the under, over and busy sticky flags once disabled and quiet
   always_comb begin
      hw_clr = '0;
      // the two live level bits need no clearing here
      hw_clr[BIT_RX_UNDER] = idle_off;
      hw_clr[BIT_RX_OVER] = idle_off;
      hw_clr[BIT_TX_OVER] = idle_off;
      hw_clr[BIT_BUSY_SEEN] = idle_off;
   end

   // one copy of the state filled here, registered below
   always_comb begin
      next_s = s;

      // sticky flags: a set in the clearing cycle wins
      next_s.raw_flags = set_vec |
                         (s.raw_flags & ~clr_vec & ~hw_clr);
      // level bits are rebuilt live, never stored
      next_s.raw_flags[BIT_RX_FULL] = 1'b0;
      next_s.raw_flags[BIT_TX_EMPTY] = 1'b0;

      // abort cause bits, new causes beat the clear
      next_s.abort_cause_record = abort_cause_set |
         (s.abort_cause_record & ~cause_clr);

      // tx fifo stays flushed from abort until released
      next_s.tx_flush = core_events.tx_abort ||
                        (s.tx_flush && !flush_release);

      // write address and data, either order
      if (aw_take && !do_write) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (w_take && !do_write) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end

      // perform the write once both halves are here
      if (do_write) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         case (wr_addr)
            ADDR_RECEIVE_LEVEL: begin
               // values above 3 are stored but not meaningful
               if (wr_strb[0]) begin
                  next_s.receive_level_trigger =
                     wr_data[TRIG_W-1:0];
               end
            end
            ADDR_TRANSMIT_LEVEL: begin
               // the whole field sits in the low byte lane
               if (wr_strb[0]) begin
                  next_s.transmit_level_trigger =
                     wr_data[TRIG_W-1:0];
               end
            end
            // read-only words take the write without effect
            ADDR_RAW_EVENT_STATUS, ADDR_ABORT_CAUSE, ADDR_CLEAR_ALL,
            ADDR_CLEAR_RX_UNDER, ADDR_CLEAR_RX_OVER,
            ADDR_CLEAR_TX_OVER, ADDR_CLEAR_RD_REQ,
            ADDR_CLEAR_TX_ABORT, ADDR_CLEAR_SEND_DONE,
            ADDR_CLEAR_BUSY_SEEN: begin
               next_s.bresp = RESP_OKAY;
            end
            default: begin
               next_s.bresp = RESP_SLVERR;
            end
         endcase
      end else if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      // read answer registered one edge after the address
      if (ar_take) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = rd_resp;
         next_s.rdata = {16'h0000, rd_word};
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
   end

   // state register, frozen while clk_en is low
   // reset does not wait for clk_en, so a frozen block still clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= STATE_RESET;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // outputs to the core
   // ------------------------------------------------------------
   // a disabled controller also keeps its tx fifo flushed
   assign tx_fifo_flush = s.tx_flush || !core_enabled;
   // clock stretched while the read request waits for software
   assign scl_hold_low = s.raw_flags[BIT_RD_REQ];
   // level flags are live, so these two follow the inputs at once
   assign intr_combined = |full_flags;
   assign raw_event_status = full_flags;

endmodule

// ---- tb/ift_core_model.sv ----
/*
 far side model: controller core events and the shared clock line.
 assumes the bench asks for events one cycle ahead.
*/
module ift_core_model
   import ift_pkg::*;
(
   // clock
   input wire logic aclk,
   // requests from the bench
   input wire ift_evt_type evt_req,
   input wire logic [CAUSE_W-1:0] cause_req,
   // block output
   input wire logic scl_hold_low,
   // towards block and wire
   output ift_evt_type core_events = '0,
   output logic [CAUSE_W-1:0] abort_cause_set = '0,
   output logic scl_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // events leave as single-cycle pulses, launched off the edge
   always @(posedge aclk) begin
      core_events <= evt_req;
      abort_cause_set <= evt_req.tx_abort ? cause_req : 16'h0000;
   end
   // pulled-up line: reads high once the block lets go
   assign scl_line = !scl_hold_low;
endmodule

// ---- tb/ift_event_clear_chk.sv ----
/*
 port checker of the event clear block, bound to ift_event_clear.
 assumes one clock domain and a synchronous active-low reset.
*/
module ift_chk
   import ift_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // read channels
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   // controller core side
   input wire logic core_enabled,
   input wire logic core_active,
   input wire ift_evt_type core_events,
   input wire logic tx_fifo_flush,
   input wire logic scl_hold_low,
   input wire logic intr_combined,
   input wire logic [FLAG_W-1:0] raw_event_status
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic quiet;
   // a set in the same cycle would win, so clears are judged only in calm
   assign quiet = core_events == '0;
   // ------------------------------------------------------------
   // read steps
   // ------------------------------------------------------------
   sequence s_ar;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_rd(logic [31:0] a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   a_ar_answer: assert property (s_ar |=> s_axi_rvalid)
      else $error("read answer late");
   a_clear_upper: assert property (
      s_ar ##0 s_axi_araddr >= ADDR_CLEAR_ALL &&
      s_axi_araddr <= ADDR_CLEAR_BUSY_SEEN |=> s_axi_rdata[31:1] == '0)
      else $error("clear word upper bits set");
   a_under_clear: assert property (
      s_rd(ADDR_CLEAR_RX_UNDER) ##0 quiet |=>
      !raw_event_status[BIT_RX_UNDER] &&
      s_axi_rdata[0] == $past(raw_event_status[BIT_RX_UNDER]))
      else $error("underflow clear wrong");
   a_all_clear: assert property (
      s_rd(ADDR_CLEAR_ALL) ##0 quiet |=>
      raw_event_status[7:5] == 3'h0 && !raw_event_status[BIT_TX_OVER] &&
      raw_event_status[1:0] == 2'h0 && s_axi_rdata[0] == $past(intr_combined))
      else $error("clear all wrong");
   a_busy_kept: assert property (
      s_rd(ADDR_CLEAR_BUSY_SEEN) ##0 core_active &&
      raw_event_status[BIT_BUSY_SEEN] |=> raw_event_status[BIT_BUSY_SEEN])
      else $error("busy flag lost while active");
   a_abort_release: assert property (
      s_rd(ADDR_CLEAR_TX_ABORT) ##0 quiet |=> !tx_fifo_flush || !core_enabled)
      else $error("tx fifo still flushed");
   a_abort_flush: assert property (clk_en && core_events.tx_abort
      |=> tx_fifo_flush)
      else $error("abort did not flush");
   a_event_sets: assert property (clk_en && core_events.rx_over
      |=> raw_event_status[BIT_RX_OVER])
      else $error("overflow event lost");
   a_hold_low: assert property (clk_en && core_events.rd_req
      |=> scl_hold_low)
      else $error("clock not held on read request");
   a_off_flush: assert property (!core_enabled |->
      !raw_event_status[BIT_RX_FULL] && tx_fifo_flush)
      else $error("disabled fifo not flushed");
   a_intr_or: assert property (intr_combined == |raw_event_status)
      else $error("combined output wrong");
endmodule

bind ift_event_clear ift_chk ift_chk_i (.aclk, .aresetn, .clk_en,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .core_enabled, .core_active, .core_events, .tx_fifo_flush,
   .scl_hold_low, .intr_combined, .raw_event_status);

// ---- tb/tb_top.sv ----
/*
 self-checking bench of the event clear block.
 assumes the block answers every bus request; a cycle ceiling ends hangs.
*/
module tb_top
   import ift_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, clk_en = 1;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, tx_fifo_flush, scl_hold_low, intr_combined, scl_line;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic core_enabled = 1, core_active = 0, abort_cause_keep = 0;
   logic [5:0] rx_fifo_level = '0, tx_fifo_level = '0;
   ift_evt_type evt_req = '0, core_events;
   logic [CAUSE_W-1:0] cause_req = '0, abort_cause_set;
   logic [FLAG_W-1:0] raw_event_status;
   int num_errors = 0, samples_checked = 0, cyc = 0, lv, lt, bp;

   always #50 aclk = ~aclk;

   ift_event_clear #(.LEVEL_W(6)) ift_event_clear_i (.aclk, .aresetn,
      .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .core_enabled, .core_active, .rx_fifo_level,
      .tx_fifo_level, .core_events, .abort_cause_set, .abort_cause_keep,
      .tx_fifo_flush, .scl_hold_low, .intr_combined, .raw_event_status);
   ift_core_model ift_core_model_i (.aclk, .evt_req, .cause_req,
      .scl_hold_low, .core_events, .abort_cause_set, .scl_line);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   // write: address and data offered together, each dropped when taken
   task automatic axw(input logic [31:0] a, d, input logic [3:0] s);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   // read: the spare edge at the end keeps rready from toggling twice
   task automatic axr(input logic [31:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic pulse(input ift_evt_type e);
      evt_req <= e;
      @(posedge aclk);
      evt_req <= '0;
      repeat (2) @(posedge aclk);
   endtask
   function automatic logic exp_rx(int s, int l);
      return l >= s + 1;
   endfunction
   function automatic logic exp_tx(int s, int l);
      return l <= ((s == 3) ? 4 : s);
   endfunction

   // hang guard, well above the few hundred cycles needed
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         test_done;
      end
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'ha0f10049));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(ADDR_RECEIVE_LEVEL);
      chk("rx trigger reset", 32'h0, rd);
      axr(ADDR_TRANSMIT_LEVEL);
      chk("tx trigger reset", 32'h0, rd);
      $display("reset values done");
      for (int s = 0; s < 4; s++) begin
         axw(ADDR_RECEIVE_LEVEL, 32'(s), 4'($urandom) | 4'h1);
         axw(ADDR_TRANSMIT_LEVEL, 32'(s), 4'($urandom) | 4'h1);
         axr(ADDR_RECEIVE_LEVEL);
         chk("rx trigger", 32'(s), rd);
         repeat (5) begin
            lv = $urandom_range(5);
            lt = $urandom_range(5);
            rx_fifo_level <= 6'(lv);
            tx_fifo_level <= 6'(lt);
            @(posedge aclk);
            chk("rx full", 32'(exp_rx(s, lv)),
               32'(raw_event_status[BIT_RX_FULL]));
            chk("tx low", 32'(exp_tx(s, lt)),
               32'(raw_event_status[BIT_TX_EMPTY]));
         end
      end
      axw(ADDR_RECEIVE_LEVEL, 32'h1, 4'he);
      axr(ADDR_RECEIVE_LEVEL);
      chk("masked write", 32'h3, rd);
      axr(32'h5000_15f0);
      chk("unmapped read", 32'(RESP_SLVERR), 32'(rsp));
      axw(32'h5000_15f0, 32'h1, 4'hf);
      chk("unmapped write", 32'(RESP_SLVERR), 32'(rsp));
      $display("threshold test done");
      rx_fifo_level <= '0;
      tx_fifo_level <= 6'h05;
      for (int i = 0; i < 7; i++) begin
         bp = (i < 2) ? i : (i == 2) ? 3 : i + 2;
         cause_req <= 16'($urandom) | 16'h0001;
         pulse(ift_evt_type'(7'h40 >> i));
         chk("flag set", 32'h1, 32'(raw_event_status[bp]));
         if (i == 3) chk("clock held", 32'h0, 32'(scl_line));
         if (i == 4) chk("flushed", 32'h1, 32'(tx_fifo_flush));
         axr(ADDR_CLEAR_RX_UNDER + 32'(4 * i));
         chk("clear word", 32'h1, rd);
         chk("flag cleared", 32'h0, 32'(raw_event_status[bp]));
         axr(ADDR_CLEAR_RX_UNDER + 32'(4 * i));
         chk("clear again", 32'h0, rd);
      end
      chk("clock free", 32'h1, 32'(scl_line));
      chk("fifo released", 32'h0, 32'(tx_fifo_flush));
      axr(ADDR_ABORT_CAUSE);
      chk("cause cleared", 32'h0, rd);
      $display("single clear test done");
      core_active <= 1'b1;
      pulse(ift_evt_type'(7'h01));
      axr(ADDR_CLEAR_BUSY_SEEN);
      chk("busy word", 32'h1, rd);
      chk("busy kept", 32'h1, 32'(raw_event_status[BIT_BUSY_SEEN]));
      core_active <= 1'b0;
      core_enabled <= 1'b0;
      rx_fifo_level <= 6'h3f;
      repeat (2) @(posedge aclk);
      chk("busy self clear", 32'h0,
         32'(raw_event_status[BIT_BUSY_SEEN]));
      chk("rx full off", 32'h0, 32'(raw_event_status[BIT_RX_FULL]));
      chk("off flush", 32'h1, 32'(tx_fifo_flush));
      core_enabled <= 1'b1;
      $display("activity test done");
      clk_en <= 1'b0;
      pulse(ift_evt_type'(7'h20));
      chk("frozen flag", 32'h0, 32'(raw_event_status[BIT_RX_OVER]));
      chk("frozen ready", 32'h0, 32'(s_axi_arready));
      clk_en <= 1'b1;
      $display("clock enable test done");
      abort_cause_keep <= 1'b1;
      cause_req <= 16'h0201;
      pulse(ift_evt_type'(7'h7f));
      axr(ADDR_CLEAR_ALL);
      chk("clear all word", 32'h1, rd);
      chk("after clear all", 32'h004, 32'(raw_event_status));
      axr(ADDR_ABORT_CAUSE);
      chk("cause kept bit", 32'h200, rd);
      abort_cause_keep <= 1'b0;
      $display("clear all test done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(ADDR_RECEIVE_LEVEL);
      chk("rx trigger after reset", 32'h0, rd);
      $display("mid-run reset test done");
      test_done;
   end
endmodule
